/* logic/sasc_pkg.sv */
// Purpose: Shared constants and types of the serial audio/serial control block.
// Assumes: 32-bit AXI4-Lite register access, one word per register.
// Notes: Bit positions index the control, second control and status words.
package sasc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_CONTROL2 = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [31:0] CONTROL_MASK = 32'hff83_bfff;
	localparam logic [31:0] CONTROL2_MASK = 32'h0000_0080;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL2_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int B_FRAMED = 31;
	localparam int B_SYNC_DIR = 30;
	localparam int B_SYNC_POL = 29;
	localparam int B_MSEL_AUTO = 28;
	localparam int B_PULSE_W = 27;
	localparam int B_CHAR_CNT = 24;
	localparam int B_BAUD_SEL = 23;
	localparam int B_SYNC_EDGE = 17;
	localparam int B_FIFO_EN = 16;
	localparam int B_ON = 15;
	localparam int B_STOP_IDLE = 13;
	localparam int B_OUT_DIS = 12;
	localparam int B_WIDTH_HI = 11;
	localparam int B_WIDTH_LO = 10;
	localparam int B_SAMPLE = 9;
	localparam int B_CLK_EDGE = 8;
	localparam int B_SS_USE = 7;
	localparam int B_CKP = 6;
	localparam int B_MASTER = 5;
	localparam int B_IN_DIS = 4;
	localparam int B_TX_IRQ = 2;
	localparam int B_RX_IRQ = 0;
	localparam int B_AUDIO = 7;
	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int S_RX_CNT = 24;
	localparam int S_TX_CNT = 16;
	localparam int S_BUSY = 11;
	localparam int S_SHIFT_EMPTY = 7;
	localparam int S_RX_EMPTY = 5;
	localparam int S_TX_EMPTY = 3;
	localparam int S_TX_FULL = 1;
	localparam int S_RX_FULL = 0;
	// ----------------------------------------------------------------
	// Codes and widths
	// ----------------------------------------------------------------
	localparam logic [1:0] IRQ_ANY = 2'h3;
	localparam logic [1:0] IRQ_HALF = 2'h2;
	localparam logic [1:0] IRQ_ONE = 2'h1;
	localparam logic [2:0] SYNC_CODE_MAX = 3'h5;
	localparam logic [5:0] BITS_8 = 6'h08;
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] BITS_32 = 6'h20;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_LEAD = 2'h1, ST_SHIFT = 2'h3, ST_DONE = 2'h2} sasc_state_t;
endpackage

/* logic/sasc_fifo_if.sv */
// Purpose: Carrier between the control logic and one data buffer.
// Assumes: Push and pop are single-cycle strobes on the owner's clock.
// Notes: The owner refuses pushes above its effective depth.
`timescale 1ns/10ps
interface sasc_fifo_if #(parameter int WIDTH = 32, parameter int CNT_W = 5);
	logic push;
	logic pop;
	logic flush;
	logic [WIDTH-1:0] wdata;
	logic [WIDTH-1:0] rdata;
	logic [CNT_W-1:0] count;
	modport user(output push, pop, flush, wdata, input rdata, count);
	modport store(input push, pop, flush, wdata, output rdata, count);
endinterface

/* logic/sasc_fifo.sv */
// Purpose: Circular data buffer for transmit or receive words.
// Assumes: The user never pushes when full nor pops when empty.
// Notes: Flush empties the buffer in one cycle.
`timescale 1ns/10ps
module sasc_fifo #(parameter int WIDTH = 32, parameter int DEPTH = 4, parameter int CNT_W = 5)
(
	input wire logic clk_i,
	input wire logic rst_i,
	sasc_fifo_if.store port
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH >= (1 << CNT_W))
	begin : g_bad_depth
		$error("sasc_fifo: DEPTH must be a power of two that the count can hold");
	end

	always_ff @(posedge clk_i)
	begin
		if (port.push)
		begin
			mem[wr_ptr] <= port.wdata;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || port.flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (port.push)
			begin
				wr_ptr <= PTR_W'(wr_ptr + 1'b1);
			end
			if (port.pop)
			begin
				rd_ptr <= PTR_W'(rd_ptr + 1'b1);
			end
			count <= CNT_W'(count + CNT_W'(port.push) - CNT_W'(port.pop));
		end
	end

	assign port.rdata = mem[rd_ptr];
	assign port.count = count;
endmodule

/* logic/sasc_top.sv */
// Purpose: Serial port control with framed sync, audio widths and data buffers.
// Assumes: CLK_I is the peripheral bus clock; pins arrive asynchronously.
// Notes: Every pin and interrupt output is registered once after the engine.
// Functional notes
// R01: Framed mode turns select pin into sync.
// R02: Sync direction bit: external or generated sync.
// R03: Sync polarity bit sets active sync level.
// R04: Master auto-select drives select pin during transfers.
// R05: Sync pulse lasts one character or bit.
// R06: Sync every 1 to 32 characters.
// R07: Baud clock from reference or bus clock.
// R08: Sync coincides with or precedes first bit.
// R09: Buffer bit selects multi-element or single buffer.
// R10: Clock source and buffer bits locked while on.
// R11: Enable and stop-in-idle control running.
// R12: Output/input disable bits release data pins.
// R13: Audio width bits pick data and channel.
// R14: Non-audio widths are 32, 16 or 8.
// R15: Role bit; master samples middle or end.
// R16: Slave always samples at the middle.
// R17: Clock edge bit picks output change edge.
// R18: Clock polarity sets idle level; audio forces high.
// R19: Slave uses select pin only when enabled.
// R20: Transmit interrupt threshold per mode field.
// R21: Receive interrupt threshold per mode field.
// R22: Audio enable changes widths and clock polarity.
// R23: Disabling returns engine and counters to idle.
`timescale 1ns/10ps
module sasc_top #(parameter int FIFO_DEPTH = 4, parameter int HALF_DIV = 4)
(
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic CPU_IDLE_I,
	input wire logic REFERENCE_CLOCK_OUT_I,
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE_O,
	input wire logic SERIAL_IN_PIN_I,
	output logic SERIAL_OUT_PIN_O,
	output logic SERIAL_OUT_PIN_OE_O,
	input wire logic SELECT_PIN_I,
	output logic SELECT_PIN_O,
	output logic SELECT_PIN_OE_O,
	output logic TX_IRQ_O,
	output logic RX_IRQ_O
);
	import sasc_pkg::*;

	localparam int CNT_W = 5;

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16 || HALF_DIV < 1 || HALF_DIV > 65535)
	begin : g_bad_param
		$error("sasc_top: FIFO_DEPTH must be 2..16 and HALF_DIV 1..65535");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] data_bits(input logic aud, input logic hi, input logic lo);
		if (aud)
			data_bits = (hi && lo) ? BITS_24 : (hi ? BITS_32 : BITS_16); // R13
		else
			data_bits = hi ? BITS_32 : (lo ? BITS_16 : BITS_8); // R14
	endfunction

	function automatic logic [5:0] chan_bits(input logic aud, input logic hi, input logic lo);
		if (aud)
			chan_bits = (hi || lo) ? BITS_32 : BITS_16; // R13
		else
			chan_bits = data_bits(1'b0, hi, lo);
	endfunction

	function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
		strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// ----------------------------------------------------------------
	// Registers and decoded fields
	// ----------------------------------------------------------------
	logic [31:0] control;
	logic [31:0] control2;
	logic on, framed, sync_dir, sync_pol, msel_auto, pulse_w, baud_sel, edge_sel, fifo_en;
	logic stop_idle, out_dis, in_dis, sample_phase, cke, ss_use, master, audio;
	logic [2:0] char_code;
	logic [1:0] tx_mode, rx_mode;
	assign on = control[B_ON];
	assign framed = control[B_FRAMED];
	assign sync_dir = control[B_SYNC_DIR];
	assign sync_pol = control[B_SYNC_POL];
	assign msel_auto = control[B_MSEL_AUTO];
	assign pulse_w = control[B_PULSE_W];
	assign char_code = control[B_CHAR_CNT +: 3];
	assign baud_sel = control[B_BAUD_SEL];
	assign edge_sel = control[B_SYNC_EDGE];
	assign fifo_en = control[B_FIFO_EN];
	assign stop_idle = control[B_STOP_IDLE];
	assign out_dis = control[B_OUT_DIS];
	assign in_dis = control[B_IN_DIS];
	assign cke = control[B_CLK_EDGE];
	assign ss_use = control[B_SS_USE];
	assign master = control[B_MASTER];
	assign tx_mode = control[B_TX_IRQ +: 2];
	assign rx_mode = control[B_RX_IRQ +: 2];
	assign audio = control2[B_AUDIO];
	assign sample_phase = master & control[B_SAMPLE]; // R15 R16

	logic idle_lvl;
	assign idle_lvl = audio | control[B_CKP]; // R18 R22

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pin_s1, pin_s2;
	logic sck_prev, ref_prev;
	always_ff @(posedge CLK_I)
	begin
		pin_s1 <= {SCK_I, SERIAL_IN_PIN_I, SELECT_PIN_I, REFERENCE_CLOCK_OUT_I, CPU_IDLE_I};
		pin_s2 <= pin_s1;
		sck_prev <= pin_s2[4];
		ref_prev <= pin_s2[1];
	end

	logic sdi_bit, ss_in, idle_in, run;
	assign sdi_bit = pin_s2[3] & ~in_dis; // R12
	assign ss_in = pin_s2[2];
	assign idle_in = pin_s2[0];
	assign run = on & ~(stop_idle & idle_in); // R11

	// ----------------------------------------------------------------
	// Data buffers
	// ----------------------------------------------------------------
	sasc_fifo_if #(.WIDTH(32), .CNT_W(CNT_W)) tx ();
	sasc_fifo_if #(.WIDTH(32), .CNT_W(CNT_W)) rx ();
	sasc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_tx_fifo (.clk_i(CLK_I), .rst_i(SYS_RST_I), .port(tx));
	sasc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_rx_fifo (.clk_i(CLK_I), .rst_i(SYS_RST_I), .port(rx));

	logic [CNT_W-1:0] eff_depth, half_depth;
	logic tx_full, tx_has, rx_full, rx_has;
	assign eff_depth = fifo_en ? CNT_W'(FIFO_DEPTH) : CNT_W'(1); // R09
	assign half_depth = CNT_W'((eff_depth + 1'b1) >> 1);
	assign tx_full = tx.count >= eff_depth;
	assign tx_has = tx.count != '0;
	assign rx_full = rx.count >= eff_depth;
	assign rx_has = rx.count != '0;
	assign tx.flush = ~on; // R23
	assign rx.flush = ~on; // R23

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic aw_got, w_got, do_write;
	logic [7:0] waddr;
	logic [31:0] wdata, wmask;
	assign do_write = aw_got & w_got & ~S_AXI_BVALID_O;
	assign wmask = strobe_mask(S_AXI_WSTRB_I);
	assign tx.push = do_write & (waddr == ADDR_DATA) & ~tx_full;
	assign tx.wdata = wdata;

	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			S_AXI_AWREADY_O <= 1'b1;
			S_AXI_WREADY_O <= 1'b1;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			waddr <= '0;
			wdata <= '0;
			control <= CONTROL_RESET;
			control2 <= CONTROL2_RESET;
		end
		else
		begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			begin
				aw_got <= 1'b1;
				waddr <= {S_AXI_AWADDR_I[7:2], 2'b00};
				S_AXI_AWREADY_O <= 1'b0;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O)
			begin
				w_got <= 1'b1;
				wdata <= S_AXI_WDATA_I & wmask;
				S_AXI_WREADY_O <= 1'b0;
				if (!S_AXI_AWREADY_O || S_AXI_AWVALID_I)
				begin
					wdata <= S_AXI_WDATA_I;
				end
			end
			if (do_write)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= RESP_OKAY;
				case (waddr)
					ADDR_CONTROL:
					begin
						control <= (wdata & CONTROL_MASK) | (control & ~CONTROL_MASK);
						if (on)
						begin
							control[B_BAUD_SEL] <= baud_sel; // R10
							control[B_FIFO_EN] <= fifo_en; // R10
						end
					end
					ADDR_CONTROL2:
					begin
						if (!on)
						begin
							control2 <= wdata & CONTROL2_MASK; // R22
						end
					end
					ADDR_DATA, ADDR_STATUS: ;
					default: S_AXI_BRESP_O <= RESP_SLVERR;
				endcase
			end
			if (S_AXI_BVALID_O && S_AXI_BREADY_I)
			begin
				S_AXI_BVALID_O <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
				S_AXI_WREADY_O <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	sasc_state_t state;
	logic [7:0] raddr;
	logic [31:0] status;
	assign raddr = {S_AXI_ARADDR_I[7:2], 2'b00};
	assign rx.pop = S_AXI_ARVALID_I & S_AXI_ARREADY_O & (raddr == ADDR_DATA) & rx_has;
	always_comb
	begin
		status = '0;
		status[S_RX_CNT +: CNT_W] = rx.count;
		status[S_TX_CNT +: CNT_W] = tx.count;
		status[S_BUSY] = state != ST_IDLE;
		status[S_SHIFT_EMPTY] = state == ST_IDLE;
		status[S_RX_EMPTY] = ~rx_has;
		status[S_TX_EMPTY] = ~tx_has;
		status[S_TX_FULL] = tx_full;
		status[S_RX_FULL] = rx_full;
	end

	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= '0;
			S_AXI_RRESP_O <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RRESP_O <= RESP_OKAY;
			case (raddr)
				ADDR_CONTROL: S_AXI_RDATA_O <= control;
				ADDR_CONTROL2: S_AXI_RDATA_O <= control2;
				ADDR_DATA: S_AXI_RDATA_O <= rx_has ? rx.rdata : '0;
				ADDR_STATUS: S_AXI_RDATA_O <= status;
				default:
				begin
					S_AXI_RDATA_O <= '0;
					S_AXI_RRESP_O <= RESP_SLVERR;
				end
			endcase
		end
		else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
		begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_ARREADY_O <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Baud generator
	// ----------------------------------------------------------------
	logic [15:0] div_cnt;
	logic src_tick, half_tick;
	assign src_tick = baud_sel ? (pin_s2[1] & ~ref_prev) : 1'b1; // R07
	assign half_tick = src_tick && (div_cnt == 16'(HALF_DIV - 1));
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I || !run || state == ST_IDLE)
		begin
			div_cnt <= '0; // R23
		end
		else if (src_tick)
		begin
			div_cnt <= half_tick ? '0 : 16'(div_cnt + 1'b1);
		end
	end

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	logic [5:0] nb, db, glen;
	logic [6:0] k, last_k;
	logic [31:0] shreg, rxreg, load_word;
	logic [4:0] fcnt;
	logic act, sdo, sync_act, xfer, gen_sync, sync_in, start, evt, ss_ok;
	assign nb = chan_bits(audio, control[B_WIDTH_HI], control[B_WIDTH_LO]);
	assign db = data_bits(audio, control[B_WIDTH_HI], control[B_WIDTH_LO]);
	assign glen = (char_code > SYNC_CODE_MAX) ? 6'h01 : 6'(6'h01 << char_code); // R06
	assign last_k = 7'({nb, 1'b0} - 1'b1 + 7'(sample_phase & ~cke)); // R15
	assign load_word = tx_has ? 32'(tx.rdata << (BITS_32 - db)) : '0;
	assign gen_sync = framed & ~sync_dir & master; // R01 R02
	assign sync_in = ss_in == sync_pol; // R03
	assign ss_ok = framed ? (~sync_dir | sync_in) : (master | ~ss_use | ~ss_in); // R02 R19
	assign start = master ? (tx_has & ss_ok) : ss_ok;
	assign evt = master ? half_tick : (pin_s2[4] != sck_prev);
	assign tx.pop = run & (state == ST_IDLE) & start & tx_has;
	assign rx.push = run & (state == ST_DONE) & ~rx_full;
	assign rx.wdata = 32'((rxreg >> (nb - db)) & ((db == BITS_32) ? 32'hffff_ffff : 32'((33'h1 << db) - 1'b1)));

	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I || !on)
		begin
			state <= ST_IDLE; // R23
			k <= '0;
			act <= 1'b0;
			sdo <= 1'b0;
			shreg <= '0;
			rxreg <= '0;
			sync_act <= 1'b0;
			xfer <= 1'b0;
			fcnt <= '0;
		end
		else if (run)
		begin
			case (state)
				ST_IDLE:
				begin
					if (start)
					begin
						k <= '0;
						xfer <= 1'b1;
						sync_act <= gen_sync && fcnt == '0; // R06
						shreg <= cke ? 32'(load_word << 1) : load_word;
						if (cke)
						begin
							sdo <= load_word[31]; // R17
						end
						state <= (gen_sync && fcnt == '0 && !edge_sel) ? ST_LEAD : ST_SHIFT; // R08
					end
				end
				ST_LEAD:
				begin
					if (half_tick)
					begin
						act <= ~act;
						k <= 7'(k + 1'b1);
						if (k[0])
						begin
							k <= '0;
							state <= ST_SHIFT;
							if (!pulse_w)
							begin
								sync_act <= 1'b0; // R05
							end
						end
					end
				end
				ST_SHIFT:
				begin
					if (!master && !framed && ss_use && ss_in)
					begin
						state <= ST_IDLE; // R19
						xfer <= 1'b0;
						act <= 1'b0;
					end
					else if (evt)
					begin
						if (k < {nb, 1'b0})
						begin
							act <= ~act;
						end
						if ((k[0] ^ cke ^ sample_phase) && !(sample_phase && !cke && k == '0))
						begin
							rxreg <= {rxreg[30:0], sdi_bit}; // R15 R16
						end
						if (k[0] == cke && (k + 7'(cke)) < {nb, 1'b0})
						begin
							sdo <= shreg[31]; // R17
							shreg <= {shreg[30:0], 1'b0};
						end
						if (k == 7'h1 && edge_sel && !pulse_w)
						begin
							sync_act <= 1'b0; // R05 R08
						end
						k <= 7'(k + 1'b1);
						if (k == last_k)
						begin
							act <= 1'b0;
							state <= ST_DONE;
						end
					end
				end
				ST_DONE:
				begin
					xfer <= 1'b0;
					sync_act <= 1'b0; // R05
					rxreg <= '0;
					fcnt <= ({1'b0, fcnt} == 6'(glen - 1'b1)) ? '0 : 5'(fcnt + 1'b1); // R06
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin and interrupt outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			SCK_O <= 1'b0;
			SCK_OE_O <= 1'b0;
			SERIAL_OUT_PIN_O <= 1'b0;
			SERIAL_OUT_PIN_OE_O <= 1'b0;
			SELECT_PIN_O <= 1'b0;
			SELECT_PIN_OE_O <= 1'b0;
			TX_IRQ_O <= 1'b0;
			RX_IRQ_O <= 1'b0;
		end
		else
		begin
			SCK_O <= idle_lvl ^ act; // R18
			SCK_OE_O <= on & master;
			SERIAL_OUT_PIN_O <= sdo;
			SERIAL_OUT_PIN_OE_O <= on & ~out_dis; // R12
			SELECT_PIN_O <= 1'b0;
			SELECT_PIN_OE_O <= 1'b0;
			if (on && gen_sync)
			begin
				SELECT_PIN_O <= sync_act ? sync_pol : ~sync_pol; // R01 R03
				SELECT_PIN_OE_O <= 1'b1;
			end
			else if (on && master && msel_auto && !framed)
			begin
				SELECT_PIN_O <= xfer ? sync_pol : ~sync_pol; // R04
				SELECT_PIN_OE_O <= 1'b1;
			end
			case (tx_mode)
				IRQ_ANY: TX_IRQ_O <= on & ~tx_full; // R20
				IRQ_HALF: TX_IRQ_O <= on & ((eff_depth - tx.count) >= half_depth);
				IRQ_ONE: TX_IRQ_O <= on & ~tx_has;
				default: TX_IRQ_O <= on & ~tx_has & (state == ST_IDLE);
			endcase
			case (rx_mode)
				IRQ_ANY: RX_IRQ_O <= on & rx_full; // R21
				IRQ_HALF: RX_IRQ_O <= on & (rx.count >= half_depth);
				IRQ_ONE: RX_IRQ_O <= on & rx_has;
				default: RX_IRQ_O <= on & ~rx_has;
			endcase
		end
	end
endmodule

/* verification/sasc_checker.sv */
// Purpose: Concurrent checks on the register bus and interrupt pins.
// Assumes: Sees only the top ports.
// Notes: Bound into the top module below.
`timescale 1ns/10ps
module sasc_checker
	import sasc_pkg::*;
(
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic S_AXI_AWVALID_I,
	input logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input logic S_AXI_WREADY_O,
	input logic [1:0] S_AXI_BRESP_O,
	input logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input logic S_AXI_ARREADY_O,
	input logic [31:0] S_AXI_RDATA_O,
	input logic [1:0] S_AXI_RRESP_O,
	input logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input logic TX_IRQ_O,
	input logic RX_IRQ_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	sequence wr_taken;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence rd_taken;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	write_answer_a: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID_O)
		else $error("write response late");
	read_answer_a: assert property (rd_taken |=> S_AXI_RVALID_O)
		else $error("read response late");
	rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data dropped");
	bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped");
	wready_low_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write ready while answering");
	arready_low_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
		else $error("read ready while answering");
	err_data_a: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR |-> S_AXI_RDATA_O == 32'h0)
		else $error("error read carries data");
	irq_reset_a: assert property ($fell(SYS_RST_I) |-> !TX_IRQ_O && !RX_IRQ_O)
		else $error("interrupt high after reset");
endmodule
bind sasc_top sasc_checker axi_chk (.CLK_I, .SYS_RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I,
	.S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
	.S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .TX_IRQ_O, .RX_IRQ_O);

/* verification/sasc_partner.sv */
// Purpose: Behavioural serial slave facing the master pins.
// Assumes: Enabled by the bench only while a character is on the wire.
// Notes: Between characters the data line shows the inverse of its last bit.
`timescale 1ns/10ps
module sasc_partner #(parameter int BITS = 8)
(
	input wire logic en_i,
	input wire logic ckp_i,
	input wire logic sck_i,
	input wire logic sdo_i,
	input wire logic [31:0] pat_i,
	output logic sdi_o
);
	int nbits = 0;
	logic [31:0] got = 32'h0;
	initial sdi_o = 1'b0;
	always @(sck_i)
	begin
		if (en_i && sck_i !== ckp_i)
			sdi_o = pat_i[31 - nbits % BITS];
		else if (en_i)
		begin
			got = {got[30:0], sdo_i};
			nbits++;
			if (nbits % BITS == 0)
				sdi_o = ~sdi_o;
		end
	end
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for the serial port control block.
// Assumes: Single buffer, 8-bit master characters.
// Notes: A model of the control word predicts every control readback but the first, which expects CONTROL_RESET.
`timescale 1ns/10ps
module testbench;
	import sasc_pkg::*;
	localparam logic [31:0] LOCK = (32'h1 << B_BAUD_SEL) | (32'h1 << B_FIFO_EN);
	localparam logic [31:0] RUN = (32'h1 << B_ON) | (32'h1 << B_MASTER);
	logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, refc = 1'b0, en = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00, tx;
	logic [31:0] wd = 32'h0, rdat, q, pat, ctl = 32'h0;
	logic [1:0] br, rr, r;
	logic awr, wrd, bv, arr, rv, sck, sdo, sdi, txi, rxi;
	logic idl = 1'b0, ssi = 1'b1, sckoe, sdooe;
	int err_total = 0, n_checks = 0;
	always #25 clk = ~clk;
	always @(posedge clk) refc <= ~refc;
	sasc_top #(.FIFO_DEPTH(4), .HALF_DIV(8)) dut (.CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awa),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
		.S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
		.S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .CPU_IDLE_I(idl),
		.REFERENCE_CLOCK_OUT_I(refc), .SCK_I(1'b0), .SCK_O(sck), .SCK_OE_O(sckoe), .SERIAL_IN_PIN_I(sdi),
		.SERIAL_OUT_PIN_O(sdo), .SERIAL_OUT_PIN_OE_O(sdooe), .SELECT_PIN_I(ssi), .SELECT_PIN_O(),
		.SELECT_PIN_OE_O(), .TX_IRQ_O(txi), .RX_IRQ_O(rxi));
	sasc_partner #(.BITS(8)) peer (.en_i(en), .ckp_i(ctl[B_CKP]), .sck_i(sck), .sdo_i(sdo), .pat_i(pat),
		.sdi_o(sdi));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge clk);
		awa <= a;
		ara <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		arv <= !w;
		bre <= w;
		rre <= !w;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
			if (arr)
				arv <= 1'b0;
			if ((bv && bre) || (rv && rre))
				break;
		end
		q = rdat;
		rs = w ? br : rr;
		bre <= 1'b0;
		rre <= 1'b0;
		if (n == 200)
			err_total++;
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, r);
		if (a == ADDR_CONTROL)
			ctl = ctl[B_ON] ? ((d & CONTROL_MASK & ~LOCK) | (ctl & LOCK)) : (d & CONTROL_MASK);
	endtask
	task automatic look(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, r);
		chk(q, e);
	endtask
	task automatic irq_scan(input logic full);
		for (int m = 0; m < 4; m++)
		begin
			put(ADDR_CONTROL, (ctl & ~32'hf) | (m << 2) | m);
			repeat (6) @(posedge clk);
			chk({31'h0, rxi}, {31'h0, full ? m != 0 : m == 0});
			chk({31'h0, txi}, 32'h1);
		end
	endtask
	initial
	begin
		#1000000;
		err_total++;
		stop_test;
	end
	initial
	begin
		pat = $urandom(24705);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		look(ADDR_CONTROL, CONTROL_RESET);
		put(ADDR_CONTROL, 32'hffff_ffff);
		look(ADDR_CONTROL, ctl);
		put(ADDR_CONTROL, 32'h0);
		look(ADDR_CONTROL, ctl);
		put(ADDR_CONTROL, 32'h0);
		look(ADDR_CONTROL, ctl);
		bus(1'b1, 8'h10, 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		look(8'h10, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		put(ADDR_CONTROL2, 32'h80);
		look(ADDR_CONTROL2, 32'h80);
		idl <= 1'b1;
		put(ADDR_CONTROL, RUN | (32'h1 << B_STOP_IDLE));
		repeat (10) @(posedge clk);
		chk({31'h0, sck}, 32'h1);
		chk({30'h0, sckoe, sdooe}, 32'h3);
		put(ADDR_DATA, 32'h5a);
		repeat (40) @(posedge clk);
		look(ADDR_STATUS, 32'h0001_00a2);
		put(ADDR_CONTROL, 32'h0);
		idl <= 1'b0;
		put(ADDR_CONTROL2, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			put(ADDR_CONTROL, RUN | (k << B_CKP));
			repeat (10) @(posedge clk);
			chk({31'h0, sck}, k);
			tx = 8'($urandom);
			pat = $urandom;
			en = 1'b1;
			put(ADDR_DATA, {24'h0, tx});
			for (int n = 0; n < 3000 && peer.nbits < 8 * (k + 1); n++)
				@(posedge clk);
			repeat (30) @(posedge clk);
			en = 1'b0;
			chk({24'h0, peer.got[7:0]}, {24'h0, tx});
			irq_scan(1'b1);
			look(ADDR_DATA, {24'h0, pat[31:24]});
			irq_scan(1'b0);
		end
		stop_test;
	end
endmodule
